//--- core/tmt_top.sv
// Timestamp counters, periodic event generator, clock identity and master election
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module tmt_top
    import tmt_pkg::*;
#(
    parameter longint SETTLE_COUNT = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire tmt_bus_req_type bus_req,
    output logic [31:0] rdata,
    // Precision-time engine
    input wire tmt_ptp_load_type ptp_load,
    input wire tmt_peer_type peer_info,
    // Outputs to acquisition and network logic
    output logic periodic_event,
    output logic acq_trigger,
    output logic clock_master,
    output logic [63:0] clock_identity
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic precision_sync_mode_q;
    logic run_q;
    logic trig_mode_q;
    logic [1:0] trig_src_q;
    logic [63:0] periodic_start_time_q;
    logic [63:0] periodic_interval_q;
    logic [63:0] first_event_time_q;
    logic [63:0] counter_snapshot_value_q;
    logic [47:0] mac_q;
    logic [31:0] rdata_q;
    logic first_done_q;

    // Decode
    wire wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;
    wire wr_cmd = bus_req.wr && bus_req.addr == REG_CMD;
    wire wr_start_lo = bus_req.wr && bus_req.addr == REG_START_LO;
    wire wr_start_hi = bus_req.wr && bus_req.addr == REG_START_HI;
    wire wr_int_lo = bus_req.wr && bus_req.addr == REG_INTERVAL_LO;
    wire wr_int_hi = bus_req.wr && bus_req.addr == REG_INTERVAL_HI;
    wire wr_mac_lo = bus_req.wr && bus_req.addr == REG_MAC_LO;
    wire wr_mac_hi = bus_req.wr && bus_req.addr == REG_MAC_HI;
    wire counter_clear_command = wr_cmd && bus_req.wdata[CMD_CLEAR_BIT];
    wire counter_snapshot_command = wr_cmd && bus_req.wdata[CMD_SNAP_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Tick generation

    logic [6:0] us_div_q;
    logic [3:0] ptp_res_q;
    wire us_tick = us_div_q == 7'(US_CYCLES - 1);
    wire [4:0] ptp_sum = 5'(ptp_res_q) + 5'(CLK_PERIOD_NS);
    // 10 ns clock carries one or two 8 ns units per cycle
    wire [1:0] ptp_step = (ptp_sum >= 5'(2 * PTP_TICK_NS)) ? 2'h2 : 2'h1;
    wire [4:0] ptp_res_next = ptp_sum - 5'(PTP_TICK_NS) * 5'(ptp_step);

    always_ff @(posedge clk) begin
        if (rst) begin
            us_div_q <= 7'h00;
            ptp_res_q <= 4'h0;
        end else begin
            us_div_q <= us_tick ? 7'h00 : us_div_q + 7'h01;
            ptp_res_q <= ptp_res_next[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters

    logic [63:0] us_count;
    logic [63:0] ptp_count;
    // Precision counter never honours a user clear in sync mode
    wire ptp_clear = counter_clear_command && !precision_sync_mode_q;
    wire [63:0] sel_count = precision_sync_mode_q ? ptp_count : us_count;
    // Clear that actually zeroes the selected counter
    wire sel_cleared = counter_clear_command && !precision_sync_mode_q;

    tmt_ticker #(
        .WIDTH(64)
    ) u_us_ticker (
        .clk(clk),
        .rst(rst),
        .clear(counter_clear_command),
        .load(1'b0),
        .load_value(64'h0),
        .step({1'b0, us_tick}),
        .count(us_count)
    );

    tmt_ticker #(
        .WIDTH(64)
    ) u_ptp_ticker (
        .clk(clk),
        .rst(rst),
        .clear(ptp_clear),
        .load(ptp_load.valid),
        .load_value(ptp_load.value),
        .step(ptp_step),
        .count(ptp_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Periodic event generator

    tmt_per_state_type state_q;
    tmt_per_state_type state_d;
    logic [63:0] target_q;
    logic [63:0] target_d;
    logic event_q;
    logic fire;

    wire interval_ok = periodic_interval_q != 64'h0;
    // In run the stored value is the previous event, so a new interval applies next
    wire [63:0] run_goal = target_q + periodic_interval_q;
    // First value at or past the goal fires; a step over a boundary moves it on
    wire reached = sel_count >= ((state_q == PER_RUN) ? run_goal : target_q);

    always_comb begin
        state_d = state_q;
        target_d = target_q;
        fire = 1'b0;
        case (state_q)
            PER_IDLE: begin
                target_d = 64'h0;
                if (run_q && interval_ok) begin
                    state_d = PER_SEEK;
                end
            end
            PER_SEEK: begin
                // Step through multiples until strictly past start
                if (target_q > periodic_start_time_q) begin
                    state_d = PER_ARMED;
                end else begin
                    target_d = target_q + periodic_interval_q;
                end
            end
            PER_ARMED: begin
                // Stored target survives a clear; count must climb back to it
                if (reached && !sel_cleared) begin
                    fire = 1'b1;
                    state_d = PER_RUN;
                    target_d = target_q;
                end
            end
            PER_RUN: begin
                if (sel_cleared) begin
                    // Base zero, so the next goal is one interval after the clear
                    target_d = 64'h0;
                end else if (reached) begin
                    fire = 1'b1;
                    target_d = run_goal;
                end
            end
            default: begin
                state_d = PER_IDLE;
            end
        endcase
        if (!run_q || !interval_ok) begin
            state_d = PER_IDLE;
            fire = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= PER_IDLE;
            target_q <= 64'h0;
            event_q <= 1'b0;
        end else begin
            state_q <= state_d;
            target_q <= target_d;
            event_q <= fire;
        end
    end

    // First event value and done flag
    always_ff @(posedge clk) begin
        if (rst) begin
            first_event_time_q <= 64'h0;
            first_done_q <= 1'b0;
        end else if (fire && state_q == PER_ARMED) begin
            first_event_time_q <= sel_count;
            first_done_q <= 1'b1;
        end else if (state_q == PER_IDLE && state_d == PER_SEEK) begin
            first_done_q <= 1'b0;
        end
    end

    // Trigger to acquisition logic
    logic trig_q;
    wire trig_sel = trig_mode_q && trig_src_q == TRIG_SRC_PERIODIC;
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= fire && trig_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock identity and master election

    logic [47:0] best_peer_q;
    logic [31:0] settle_q;
    logic sync_prev_q;
    logic settled_q;
    logic master_q;
    logic [63:0] clkid_q;

    wire sync_rise = precision_sync_mode_q && !sync_prev_q;
    wire peer_lower = peer_info.valid && peer_info.mac < best_peer_q;
    wire [47:0] winner_mac = (mac_q < best_peer_q) ? mac_q : best_peer_q;
    wire [63:0] eui = {winner_mac[47:24], EUI_FILL, winner_mac[23:0]};

    always_ff @(posedge clk) begin
        if (rst) begin
            best_peer_q <= 48'hffffffffffff;
            settle_q <= 32'h0;
            sync_prev_q <= 1'b0;
            settled_q <= 1'b0;
            master_q <= 1'b0;
            clkid_q <= 64'h0;
        end else begin
            sync_prev_q <= precision_sync_mode_q;
            if (sync_rise) begin
                best_peer_q <= 48'hffffffffffff;
                settle_q <= 32'(SETTLE_COUNT);
                settled_q <= 1'b0;
            end else begin
                if (peer_lower) begin
                    best_peer_q <= peer_info.mac;
                end
                if (settle_q != 32'h0) begin
                    settle_q <= settle_q - 32'h1;
                end
                settled_q <= precision_sync_mode_q && settle_q == 32'h0;
            end
            master_q <= precision_sync_mode_q && mac_q < best_peer_q;
            clkid_q <= eui;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge clk) begin
        if (rst) begin
            precision_sync_mode_q <= 1'b0;
            run_q <= 1'b0;
            trig_mode_q <= 1'b0;
            trig_src_q <= 2'h0;
            periodic_start_time_q <= START_RST;
            periodic_interval_q <= INTERVAL_RST;
            mac_q <= MAC_RST;
        end else begin
            if (wr_ctrl) begin
                precision_sync_mode_q <= bus_req.wdata[CTRL_SYNC_BIT];
                run_q <= bus_req.wdata[CTRL_RUN_BIT];
                trig_mode_q <= bus_req.wdata[CTRL_TRIG_MODE_BIT];
                trig_src_q <= bus_req.wdata[CTRL_TRIG_SRC_LSB +: 2];
            end
            if (wr_start_lo) periodic_start_time_q[31:0] <= bus_req.wdata;
            if (wr_start_hi) periodic_start_time_q[63:32] <= bus_req.wdata;
            if (wr_int_lo) periodic_interval_q[31:0] <= bus_req.wdata;
            if (wr_int_hi) periodic_interval_q[63:32] <= bus_req.wdata;
            if (wr_mac_lo) mac_q[31:0] <= bus_req.wdata;
            if (wr_mac_hi) mac_q[47:32] <= bus_req.wdata[15:0];
        end
    end

    // Snapshot keeps both halves coherent
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_snapshot_value_q <= 64'h0;
        end else if (counter_snapshot_command) begin
            counter_snapshot_value_q <= sel_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    wire [31:0] ctrl_rd = {26'h0, trig_src_q, 1'b0, trig_mode_q, run_q, precision_sync_mode_q};
    wire [31:0] status_rd = {28'h0, first_done_q, settled_q, master_q, precision_sync_mode_q};
    logic [31:0] rd_mux;

    always_comb begin
        case (bus_req.addr)
            REG_CTRL: rd_mux = ctrl_rd;
            REG_START_LO: rd_mux = periodic_start_time_q[31:0];
            REG_START_HI: rd_mux = periodic_start_time_q[63:32];
            REG_INTERVAL_LO: rd_mux = periodic_interval_q[31:0];
            REG_INTERVAL_HI: rd_mux = periodic_interval_q[63:32];
            REG_FIRST_LO: rd_mux = first_event_time_q[31:0];
            REG_FIRST_HI: rd_mux = first_event_time_q[63:32];
            REG_SNAP_LO: rd_mux = counter_snapshot_value_q[31:0];
            REG_SNAP_HI: rd_mux = counter_snapshot_value_q[63:32];
            REG_MAC_LO: rd_mux = mac_q[31:0];
            REG_MAC_HI: rd_mux = {16'h0, mac_q[47:32]};
            REG_CLKID_LO: rd_mux = clkid_q[31:0];
            REG_CLKID_HI: rd_mux = clkid_q[63:32];
            REG_STATUS: rd_mux = status_rd;
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= bus_req.rd ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata = rdata_q;
    assign periodic_event = event_q;
    assign acq_trigger = trig_q;
    assign clock_master = master_q;
    assign clock_identity = clkid_q;

endmodule

//--- inc/tmt_pkg.sv
// Shared constants and carriers for the timestamp modulo trigger block
package tmt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_START_LO = 8'h08;
    localparam logic [7:0] REG_START_HI = 8'h0c;
    localparam logic [7:0] REG_INTERVAL_LO = 8'h10;
    localparam logic [7:0] REG_INTERVAL_HI = 8'h14;
    localparam logic [7:0] REG_FIRST_LO = 8'h18;
    localparam logic [7:0] REG_FIRST_HI = 8'h1c;
    localparam logic [7:0] REG_SNAP_LO = 8'h20;
    localparam logic [7:0] REG_SNAP_HI = 8'h24;
    localparam logic [7:0] REG_MAC_LO = 8'h28;
    localparam logic [7:0] REG_MAC_HI = 8'h2c;
    localparam logic [7:0] REG_CLKID_LO = 8'h30;
    localparam logic [7:0] REG_CLKID_HI = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_SYNC_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int CTRL_TRIG_MODE_BIT = 2;
    localparam int CTRL_TRIG_SRC_LSB = 4;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int CMD_SNAP_BIT = 1;
    localparam logic [1:0] TRIG_SRC_PERIODIC = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [63:0] START_RST = 64'h0;
    localparam logic [63:0] INTERVAL_RST = 64'h0;
    localparam logic [47:0] MAC_RST = 48'h0;
    localparam logic [15:0] EUI_FILL = 16'hfffe;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int PTP_TICK_NS = 8;
    localparam longint SETTLE_MS = 2000;
    localparam longint SETTLE_CYCLES = SETTLE_MS * 1000000 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tmt_bus_req_type;

    typedef struct packed {
        logic valid;
        logic [47:0] mac;
    } tmt_peer_type;

    typedef struct packed {
        logic valid;
        logic [63:0] value;
    } tmt_ptp_load_type;

    typedef enum logic [1:0] {
        PER_IDLE,
        PER_SEEK,
        PER_ARMED,
        PER_RUN
    } tmt_per_state_type;

endpackage

//--- core/tmt_ticker.sv
// Free-running 64-bit tick counter with clear, load and step input
`timescale 1ns/100ps
module tmt_ticker
    import tmt_pkg::*;
#(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic [1:0] step,
    // Count
    output logic [WIDTH-1:0] count
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // Free run, no stop; clear beats load beats step
    assign count_d = clear ? '0 : load ? load_value : count_q + WIDTH'(step);
    assign count = count_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

//--- verif/tmt_far_model.sv
// Far-side model: precision-time engine loads and peer camera reports
`timescale 1ns/100ps
module tmt_far_model
    import tmt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests from the bench
    input wire logic load_go,
    input wire logic [63:0] load_val,
    input wire logic peer_go,
    input wire logic [47:0] peer_mac,
    // Towards the block
    output tmt_ptp_load_type ptp_load,
    output tmt_peer_type peer_info
);
    // Released fields show the inverse of the last value
    always_ff @(posedge clk) begin
        ptp_load.valid <= load_go && !rst;
        ptp_load.value <= rst ? 64'h0 : (load_go ? load_val : ~ptp_load.value);
        peer_info.valid <= peer_go && !rst;
        peer_info.mac <= rst ? 48'h0 : (peer_go ? peer_mac : ~peer_info.mac);
    end
endmodule

//--- verif/tmt_top_sva.sv
// Port-level assertions for the timestamp modulo trigger
`timescale 1ns/100ps
module tmt_top_chk
    import tmt_pkg::*;
#(
    parameter longint SETTLE_COUNT = SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire tmt_bus_req_type bus_req,
    input wire logic [31:0] rdata,
    // Far side
    input wire tmt_ptp_load_type ptp_load,
    input wire tmt_peer_type peer_info,
    // Block outputs
    input wire logic periodic_event,
    input wire logic acq_trigger,
    input wire logic clock_master,
    input wire logic [63:0] clock_identity
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of control word and own MAC
    logic [31:0] ctrl_q;
    logic [47:0] mac_q;
    wire logic wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;
    wire logic wr_mac_lo = bus_req.wr && bus_req.addr == REG_MAC_LO;
    wire logic wr_mac_hi = bus_req.wr && bus_req.addr == REG_MAC_HI;
    wire logic sync_on = ctrl_q[CTRL_SYNC_BIT];
    wire logic trig_on = ctrl_q[CTRL_TRIG_MODE_BIT]
        && ctrl_q[CTRL_TRIG_SRC_LSB +: 2] == TRIG_SRC_PERIODIC;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= 32'h0;
            mac_q <= MAC_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= bus_req.wdata;
            if (wr_mac_lo) mac_q[31:0] <= bus_req.wdata;
            if (wr_mac_hi) mac_q[47:32] <= bus_req.wdata[15:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_clear_off;
        bus_req.wr && bus_req.addr == REG_CMD && bus_req.wdata[CMD_CLEAR_BIT] && !sync_on;
    endsequence
    sequence s_lower_peer;
        sync_on && peer_info.valid && peer_info.mac < mac_q;
    endsequence
    property p_pulse;
        periodic_event |=> !periodic_event;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("periodic event longer than one cycle");
    property p_acq;
        acq_trigger == (periodic_event && $past(trig_on));
    endproperty
    a_acq: assert property (p_acq)
        else $error("trigger does not follow periodic event");
    property p_ident;
        !$past(rst) && !$past(rst, 2) |-> clock_identity[39:24] == EUI_FILL;
    endproperty
    a_ident: assert property (p_ident)
        else $error("clock identity lacks middle fill");
    property p_quiet;
        s_clear_off |-> ##2 !periodic_event [*4];
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("event right after counter clear");
    property p_rd_idle;
        !$past(bus_req.rd) |-> rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read answer cycle");
    property p_unmapped;
        bus_req.rd && bus_req.addr > REG_STATUS |=> rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_master_off;
        !sync_on && !$past(sync_on) |-> !clock_master;
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("master while sync mode off");
    property p_lower_peer;
        s_lower_peer |-> ##2 !clock_master;
    endproperty
    a_lower_peer: assert property (p_lower_peer)
        else $error("still master after lower peer");
endmodule

bind tmt_top tmt_top_chk #(.SETTLE_COUNT(SETTLE_COUNT)) u_chk (.clk, .rst, .bus_req, .rdata,
    .ptp_load, .peer_info, .periodic_event, .acq_trigger, .clock_master, .clock_identity);

//--- verif/tb_timestamp_modulo_trigger.sv
// Self-checking bench for the timestamp modulo trigger
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_timestamp_modulo_trigger import tmt_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tmt_bus_req_type req = '0;
    tmt_ptp_load_type pl;
    tmt_peer_type pi;
    logic [31:0] rdata, d;
    logic pe, acq, cm, acq_ev;
    logic [63:0] cid, v, v2, base;
    logic load_go = 1'b0;
    logic peer_go = 1'b0;
    logic [63:0] load_val = 64'h0;
    logic [47:0] peer_mac = 48'h0;
    longint t_ev, t1, tc;
    int err_total = 0;
    int n_tests = 0;
    int hits;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    tmt_top #(.SETTLE_COUNT(20)) uut (.clk, .rst, .bus_req(req), .rdata, .ptp_load(pl),
        .peer_info(pi), .periodic_event(pe), .acq_trigger(acq), .clock_master(cm),
        .clock_identity(cid));
    tmt_far_model far (.clk, .rst, .load_go, .load_val, .peer_go, .peer_mac,
        .ptp_load(pl), .peer_info(pi));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        req <= '{a, w, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic rd64(input logic [7:0] a);
        rd(a);
        v[31:0] = d;
        rd(a + 8'h4);
        v[63:32] = d;
    endtask
    task automatic snap();
        wr(REG_CMD, 32'h2);
        rd64(REG_SNAP_LO);
    endtask
    task automatic wait_ev(input int lim);
        int i;
        i = 0;
        #1;
        while (i < lim && pe !== 1'b1) begin
            @(posedge clk);
            #1;
            i++;
        end
        `CHK("event seen", 1'b1, pe)
        t_ev = $time / CLK_PERIOD_NS;
        acq_ev = acq;
        @(posedge clk);
    endtask
    task automatic peer(input logic [47:0] m);
        peer_mac <= m;
        peer_go <= 1'b1;
        @(posedge clk);
        peer_go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("id reset", 64'h000000fffe000000, cid)
        wr(REG_MAC_LO, 32'h2c3d4e5f);
        wr(REG_MAC_HI, 32'h00000a1b);
        repeat (2) @(posedge clk);
        `CHK("clock id", 64'h0a1b2cfffe3d4e5f, cid)
        rd64(REG_CLKID_LO);
        `CHK("clock id reg", 64'h0a1b2cfffe3d4e5f, v)
        rd(8'h3c);
        `CHK("unmapped", 32'h0, d)
        $display("Identity test done");
        wr(REG_CMD, 32'h1);
        repeat (1000) @(posedge clk);
        snap();
        `CHK("us ticks", 1'b1, v >= 64'ha && v <= 64'hb)
        v2 = v;
        wr(REG_SNAP_LO, 32'h0);
        rd64(REG_SNAP_LO);
        `CHK("snap ro", v2, v)
        wr(REG_CTRL, 32'h1);
        base = 64'h100000000;
        load_val <= base;
        load_go <= 1'b1;
        @(posedge clk);
        load_go <= 1'b0;
        @(posedge clk);
        wr(REG_CMD, 32'h1);
        snap();
        `CHK("ptp kept", 1'b1, v > base && v < base + 64'h40)
        v2 = v;
        repeat (94) @(posedge clk);
        snap();
        `CHK("ptp step", 1'b1, v - v2 >= 64'h7c && v - v2 <= 64'h7e)
        wr(REG_CTRL, 32'h0);
        wr(REG_CMD, 32'h1);
        snap();
        `CHK("cleared", 1'b1, v <= 64'h1)
        $display("Counter test done");
        wr(REG_START_LO, 32'h14);
        wr(REG_INTERVAL_LO, 32'ha);
        wr(REG_CMD, 32'h1);
        wr(REG_CTRL, 32'h16);
        wait_ev(3500);
        t1 = t_ev;
        `CHK("trigger", 1'b1, acq_ev)
        rd64(REG_FIRST_LO);
        `CHK("first event", 64'h1e, v)
        wait_ev(1200);
        `CHK("period", 64'h3e8, t_ev - t1)
        t1 = t_ev;
        wr(REG_INTERVAL_LO, 32'h14);
        wait_ev(2200);
        `CHK("new period", 64'h7d0, t_ev - t1)
        wr(REG_CMD, 32'h1);
        tc = $time / CLK_PERIOD_NS - 1;
        wait_ev(2200);
        `CHK("after clear", 1'b1, t_ev - tc >= 64'h76c && t_ev - tc <= 64'h7da)
        $display("Periodic test done");
        wr(REG_CTRL, 32'h0);
        wr(REG_INTERVAL_LO, 32'ha);
        wr(REG_CMD, 32'h1);
        wr(REG_CTRL, 32'h2);
        repeat (2500) @(posedge clk);
        wr(REG_CMD, 32'h1);
        tc = $time / CLK_PERIOD_NS - 1;
        wait_ev(3200);
        `CHK("no trigger", 1'b0, acq_ev)
        `CHK("late first", 1'b1, t_ev - tc >= 64'hb54 && t_ev - tc <= 64'hbc2)
        rd64(REG_FIRST_LO);
        `CHK("first kept", 64'h1e, v)
        wr(REG_CTRL, 32'h0);
        hits = 0;
        repeat (1500) begin
            @(posedge clk);
            hits += (pe === 1'b1);
        end
        `CHK("stopped", 0, hits)
        $display("Clear and stop test done");
        wr(REG_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        `CHK("lone master", 1'b1, cm)
        rd(REG_STATUS);
        `CHK("settled", 3'h7, d[2:0])
        peer(48'h0b0000000000);
        `CHK("higher peer", 1'b1, cm)
        peer(48'h010203040506);
        `CHK("lower peer", 1'b0, cm)
        `CHK("master id", 64'h010203fffe040506, cid)
        $display("Election test done");
        tally_and_finish();
    end

    initial begin
        #(CLK_PERIOD_NS * 40000);
        err_total++;
        tally_and_finish();
    end
endmodule
